// ==== pkg/cp0_regs_pkg.sv ====
// register numbers, field positions and reset values of the capability and debug group
package cp0_regs_pkg;
    // ************************************************************
    // register numbers and selects
    // ************************************************************
    localparam logic [4:0] REG_CONFIG       = 5'h10;
    localparam logic [4:0] REG_LINKED_LOAD_ADDRESS       = 5'h11;
    localparam logic [4:0] REG_DEBUG        = 5'h17;
    localparam logic [2:0] SEL_CAP_THREE    = 3'h3;
    localparam logic [2:0] SEL_CAP_FOUR     = 3'h4;
    localparam logic [2:0] SEL_CAP_FIVE     = 3'h5;
    localparam logic [2:0] SEL_IMPL_CTL     = 3'h7;
    localparam logic [2:0] SEL_ZERO         = 3'h0;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CAP_MORE_BIT      = 31;
    localparam int KSCR_LSB          = 16;
    localparam int LINKED_PAIR_BIT   = 13;
    localparam int DUAL_ENDIAN_BIT   = 11;
    localparam int BRK_RESTRICT_BIT  = 6;
    localparam int HIGH_MOVE_BIT     = 5;
    localparam int LINK_VISIBLE_BIT  = 4;
    localparam int NESTED_FAULT_BIT  = 0;
    localparam int CACHE_INIT_BIT    = 18;
    localparam int EXT_SYNC_BIT      = 8;
    localparam int PADDR_LSB         = 5;
    localparam int DBG_DBD_BIT       = 31;
    localparam int DBG_DM_BIT        = 30;
    localparam int DBG_NOSEG_BIT     = 29;
    localparam int DBG_ROUTE_BIT     = 28;
    localparam int DBG_LOWPWR_BIT    = 27;
    localparam int DBG_HALT_BIT      = 26;
    localparam int DBG_VER_LSB       = 15;
    localparam int DBG_CODE_LSB      = 10;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] KSCR_RESET       = 8'hFC;
    localparam logic       LOWPWR_RESET     = 1'h1;
    localparam logic       HALT_RESET       = 1'h0;
    localparam logic [2:0] DBG_VER_RESET    = 3'h0;
endpackage

// ==== pkg/cp0_sub_if.sv ====
// carrier between the register front end and its linked-load and debug keepers
`timescale 1ns/1ns
interface cp0_sub_if;
    logic        ll_exec;
    logic [31:0] ll_paddr;
    logic        llb_clear;
    logic        ll_wr;
    logic        dbg_exc;
    logic        dmode_exc;
    logic        deret;
    logic        delay_slot;
    logic        low_power;
    logic        bus_run;
    logic [4:0]  exc_code;
    logic        dbg_wr;
    logic [31:0] wdata;
    logic [31:0] ll_word;
    logic [31:0] dbg_word;

    modport front (output ll_exec, ll_paddr, llb_clear, ll_wr, dbg_exc, dmode_exc, deret,
                   delay_slot, low_power, bus_run, exc_code, dbg_wr, wdata,
                   input ll_word, dbg_word);
    modport ll    (input ll_exec, ll_paddr, llb_clear, ll_wr, wdata, output ll_word);
    modport dbg   (input dbg_exc, dmode_exc, deret, delay_slot, low_power, bus_run,
                   exc_code, dbg_wr, wdata, output dbg_word);
endinterface

// ==== sim/tb.sv ====
// self-checking bench for the capability, linked-load and debug register group
`timescale 1ns/1ns
module tb;
    logic        sys_clk_i, rst_n_i, ce_i, cp0_rd_i, cp0_wr_i, cp0_rvalid_o;
    logic [4:0]  cp0_reg_i, exc_code_i;
    logic [2:0]  cp0_sel_i;
    logic [31:0] cp0_wdata_i, cp0_rdata_o, ll_paddr_i, pa;
    logic        ll_exec_i, llb_clear_i, debug_exc_i, dmode_exc_i, deret_i, delay_slot_i;
    logic        low_power_i, bus_clk_run_i, software_debug_breakpoint_instr_exec_i, kernel_mode_i, sync_instr_i;
    logic        software_debug_breakpoint_instr_ri_o, sync_ext_o, debug_mode_o, seg_to_main_o, link_bit_o;
    int          n_errors, checked;
    int          ri_cnt = 0;
    int          sync_cnt = 0;

    cp0_capability_and_debug_regs i_cp0_capability_and_debug_regs (.*);

    // ************************************************************
    // clock, pulse counters, watchdog
    // ************************************************************
    initial begin
        sys_clk_i = 1'h0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        ri_cnt   <= ri_cnt + int'(software_debug_breakpoint_instr_ri_o === 1'h1);
        sync_cnt <= sync_cnt + int'(sync_ext_o === 1'h1);
    end
    initial begin
        #(40 * 4000);
        n_errors++;
        $display("watchdog expired");
        end_sim();
    end

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] r, input logic [2:0] s, input logic [31:0] d);
        @(negedge sys_clk_i);
        cp0_wr_i = 1'h1; cp0_reg_i = r; cp0_sel_i = s; cp0_wdata_i = d;
        @(negedge sys_clk_i);
        cp0_wr_i = 1'h0;
    endtask
    task automatic rd(input string what, input logic [4:0] r, input logic [2:0] s,
                      input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
        int n;
        @(negedge sys_clk_i);
        cp0_rd_i = 1'h1; cp0_reg_i = r; cp0_sel_i = s;
        @(negedge sys_clk_i);
        cp0_rd_i = 1'h0;
        for (n = 0; n < 3 && cp0_rvalid_o !== 1'h1; n++) @(negedge sys_clk_i);
        chk({what, " rvalid"}, 32'h1, {31'h0, cp0_rvalid_o});
        chk(what, exp & m, cp0_rdata_o & m);
    endtask
    task automatic settle();
        repeat (3) @(negedge sys_clk_i);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        {rst_n_i, cp0_rd_i, cp0_wr_i, cp0_reg_i, cp0_sel_i, cp0_wdata_i} = '0;
        {ll_exec_i, ll_paddr_i, llb_clear_i, debug_exc_i, dmode_exc_i, deret_i} = '0;
        {delay_slot_i, low_power_i, bus_clk_run_i, exc_code_i, software_debug_breakpoint_instr_exec_i} = '0;
        {kernel_mode_i, sync_instr_i, n_errors, checked} = '0;
        ce_i = 1'h1;
        repeat (6) @(negedge sys_clk_i);
        rst_n_i = 1'h1;
        rd("cap3", 5'h10, 3'h3, 32'h0);
        rd("cap4", 5'h10, 3'h4, 32'h80FC0000);
        rd("cap5", 5'h10, 3'h5, 32'h00000031);
        rd("impl", 5'h10, 3'h7, 32'h0);
        wr(5'h10, 3'h4, 32'hFFFFFFFF);
        wr(5'h10, 3'h5, 32'hFFFFFFFF);
        wr(5'h10, 3'h7, 32'hFFFFFFFF);
        rd("cap4 after write", 5'h10, 3'h4, 32'h80FC0000);
        rd("cap5 after write", 5'h10, 3'h5, 32'h00000071);
        rd("impl after write", 5'h10, 3'h7, 32'h00000100);
        rd("unmapped", 5'h00, 3'h0, 32'h0);
        $display("test capability words done");
        // restriction and sync control, both on then both off
        @(negedge sys_clk_i); software_debug_breakpoint_instr_exec_i = 1'h1;
        @(negedge sys_clk_i); kernel_mode_i = 1'h1;
        @(negedge sys_clk_i); software_debug_breakpoint_instr_exec_i = 1'h0; sync_instr_i = 1'h1;
        @(negedge sys_clk_i); sync_instr_i = 1'h0; kernel_mode_i = 1'h0;
        settle();
        chk("trap count", 32'h1, ri_cnt);
        chk("sync count", 32'h1, sync_cnt);
        wr(5'h10, 3'h5, 32'h0);
        wr(5'h10, 3'h7, 32'h0);
        @(negedge sys_clk_i); software_debug_breakpoint_instr_exec_i = 1'h1; sync_instr_i = 1'h1;
        @(negedge sys_clk_i); software_debug_breakpoint_instr_exec_i = 1'h0; sync_instr_i = 1'h0;
        settle();
        chk("trap count off", 32'h1, ri_cnt);
        chk("sync count off", 32'h1, sync_cnt);
        $display("test breakpoint and sync done");
        // linked-load address and link bit
        pa = 32'hABCDEF7F;
        @(negedge sys_clk_i); ll_exec_i = 1'h1; ll_paddr_i = pa;
        @(negedge sys_clk_i); ll_exec_i = 1'h0; ll_paddr_i = 32'h0;
        settle();
        chk("link out", 32'h1, {31'h0, link_bit_o});
        rd("linked_load_address", 5'h11, 3'h0, {4'h0, pa[31:5], 1'h1});
        wr(5'h11, 3'h0, 32'hFFFFFFFF);
        rd("linked_load_address w1", 5'h11, 3'h0, {4'h0, pa[31:5], 1'h1});
        wr(5'h11, 3'h0, 32'h0);
        rd("linked_load_address w0", 5'h11, 3'h0, {4'h0, pa[31:5], 1'h0});
        @(negedge sys_clk_i); ll_exec_i = 1'h1; llb_clear_i = 1'h1; ll_paddr_i = pa;
        @(negedge sys_clk_i); ll_exec_i = 1'h0;
        @(negedge sys_clk_i); llb_clear_i = 1'h0;
        settle();
        chk("link cleared", 32'h0, {31'h0, link_bit_o});
        $display("test linked load done");
        // debug register
        rd("dbg reset", 5'h17, 3'h0, 32'h08000000);
        // software leaves the debug register alone until debug mode is entered
        settle();
        chk("route reset", 32'h0, {31'h0, seg_to_main_o});
        @(negedge sys_clk_i);
        debug_exc_i = 1'h1; delay_slot_i = 1'h1; bus_clk_run_i = 1'h1;
        @(negedge sys_clk_i);
        debug_exc_i = 1'h0; delay_slot_i = 1'h0; bus_clk_run_i = 1'h0;
        settle();
        chk("mode out", 32'h1, {31'h0, debug_mode_o});
        rd("dbg exc", 5'h17, 3'h0, 32'hC4000000);
        wr(5'h17, 3'h0, 32'h10000000);
        settle();
        chk("route out", 32'h1, {31'h0, seg_to_main_o});
        @(negedge sys_clk_i);
        dmode_exc_i = 1'h1; exc_code_i = 5'h0C; low_power_i = 1'h1;
        @(negedge sys_clk_i);
        dmode_exc_i = 1'h0; exc_code_i = 5'h0; low_power_i = 1'h0;
        rd("dbg mode exc", 5'h17, 3'h0, 32'h54003000);
        @(negedge sys_clk_i); deret_i = 1'h1;
        @(negedge sys_clk_i); deret_i = 1'h0;
        settle();
        chk("mode out off", 32'h0, {31'h0, debug_mode_o});
        rd("dbg normal", 5'h17, 3'h0, 32'h0, 32'h40038000);
        $display("test debug register done");
        end_sim();
    end
endmodule

// ==== src/cp0_capability_and_debug_regs.sv ====
// system-coprocessor capability, linked-load and debug register group
`timescale 1ns/1ns
// How it works
// - third capability bit 1 reads zero
// - third capability bit 0 reads zero
// - fourth word: bit31 one, reserved bits zero
// - scratch presence field resets to 0xFC
// - fifth word bit 31 reads zero
// - linked-pair absence flag reads zero
// - dual-endian flag reads zero
// - restriction bit traps user breakpoint instruction
// - high-half move support reads one
// - link-bit visible flag reads one
// - nested-fault present flag reads one
// - cache-init flag and unused bits zero
// - externalise-sync bit sends sync to bus
// - linked-load register captures 32-byte address
// - link bit set by load-linked only
// - debug info refreshed on debug exceptions
// - outside debug mode only mode, version valid
// - cause code, halt, low-power update selectively
// - delay-slot flag records last debug exception or exception in debug mode
// - debug-mode flag follows debug mode
// - segment absence flag reports segment presence
// - routing bit steers debug-segment accesses
// - low-power flag captured, resets to one
// - bus-halt flag shows bus clock running
module cp0_capability_and_debug_regs #(
    parameter logic       SEG_ABSENT = 1'h0,
    parameter logic [2:0] DBG_VER    = cp0_regs_pkg::DBG_VER_RESET
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        cp0_rd_i,
    input  wire logic        cp0_wr_i,
    input  wire logic [4:0]  cp0_reg_i,
    input  wire logic [2:0]  cp0_sel_i,
    input  wire logic [31:0] cp0_wdata_i,
    output logic      [31:0] cp0_rdata_o,
    output logic             cp0_rvalid_o,
    input  wire logic        ll_exec_i,
    input  wire logic [31:0] ll_paddr_i,
    input  wire logic        llb_clear_i,
    input  wire logic        debug_exc_i,
    input  wire logic        dmode_exc_i,
    input  wire logic        deret_i,
    input  wire logic        delay_slot_i,
    input  wire logic        low_power_i,
    input  wire logic        bus_clk_run_i,
    input  wire logic [4:0]  exc_code_i,
    input  wire logic        software_debug_breakpoint_instr_exec_i,
    input  wire logic        kernel_mode_i,
    input  wire logic        sync_instr_i,
    output logic             software_debug_breakpoint_instr_ri_o,
    output logic             sync_ext_o,
    output logic             debug_mode_o,
    output logic             seg_to_main_o,
    output logic             link_bit_o
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [31:0] rdata;
        logic        rvalid;
        logic        breakpoint_restriction_ctl;
        logic        es;
        logic        software_debug_breakpoint_instr_ri;
        logic        sync_ext;
        logic        dm;
        logic        segment_routing_ctl;
        logic        link_bit;
    } front_state_s;

    front_state_s st_q;
    front_state_s st_d;

    cp0_sub_if sub ();

    logic        hit_cap3;
    logic        hit_cap4;
    logic        hit_cap5;
    logic        hit_impl;
    logic        hit_ll;
    logic        hit_dbg;
    logic [31:0] cap3_word;
    logic [31:0] cap4_word;
    logic [31:0] cap5_word;
    logic [31:0] impl_word;

    // ************************************************************
    // address decode
    // ************************************************************
    assign hit_cap3 = (cp0_reg_i == cp0_regs_pkg::REG_CONFIG)
                   && (cp0_sel_i == cp0_regs_pkg::SEL_CAP_THREE);
    assign hit_cap4 = (cp0_reg_i == cp0_regs_pkg::REG_CONFIG)
                   && (cp0_sel_i == cp0_regs_pkg::SEL_CAP_FOUR);
    assign hit_cap5 = (cp0_reg_i == cp0_regs_pkg::REG_CONFIG)
                   && (cp0_sel_i == cp0_regs_pkg::SEL_CAP_FIVE);
    assign hit_impl = (cp0_reg_i == cp0_regs_pkg::REG_CONFIG)
                   && (cp0_sel_i == cp0_regs_pkg::SEL_IMPL_CTL);
    assign hit_ll   = (cp0_reg_i == cp0_regs_pkg::REG_LINKED_LOAD_ADDRESS)
                   && (cp0_sel_i == cp0_regs_pkg::SEL_ZERO);
    assign hit_dbg  = (cp0_reg_i == cp0_regs_pkg::REG_DEBUG)
                   && (cp0_sel_i == cp0_regs_pkg::SEL_ZERO);

    // ************************************************************
    // read words
    // ************************************************************
    // only the two low bits of the third word belong to this group; the rest read zero
    assign cap3_word = 32'h0000_0000;

    always_comb begin
        cap4_word = 32'h0000_0000;
        cap4_word[cp0_regs_pkg::CAP_MORE_BIT] = 1'h1;
        cap4_word[cp0_regs_pkg::KSCR_LSB +: 8] = cp0_regs_pkg::KSCR_RESET;
    end

    always_comb begin
        cap5_word = 32'h0000_0000;
        cap5_word[cp0_regs_pkg::LINKED_PAIR_BIT]  = 1'h0;
        cap5_word[cp0_regs_pkg::DUAL_ENDIAN_BIT]  = 1'h0;
        cap5_word[cp0_regs_pkg::BRK_RESTRICT_BIT] = st_q.breakpoint_restriction_ctl;
        cap5_word[cp0_regs_pkg::HIGH_MOVE_BIT]    = 1'h1;
        cap5_word[cp0_regs_pkg::LINK_VISIBLE_BIT] = 1'h1;
        cap5_word[cp0_regs_pkg::NESTED_FAULT_BIT] = 1'h1;
    end

    always_comb begin
        impl_word = 32'h0000_0000;
        impl_word[cp0_regs_pkg::CACHE_INIT_BIT] = 1'h0;
        impl_word[cp0_regs_pkg::EXT_SYNC_BIT]   = st_q.es;
    end

    // ************************************************************
    // keepers of the linked-load and debug state
    // ************************************************************
    assign sub.ll_exec    = ll_exec_i;
    assign sub.ll_paddr   = ll_paddr_i;
    assign sub.llb_clear  = llb_clear_i;
    assign sub.ll_wr      = cp0_wr_i && hit_ll;
    assign sub.dbg_exc    = debug_exc_i;
    assign sub.dmode_exc  = dmode_exc_i;
    assign sub.deret      = deret_i;
    assign sub.delay_slot = delay_slot_i;
    assign sub.low_power  = low_power_i;
    assign sub.bus_run    = bus_clk_run_i;
    assign sub.exc_code   = exc_code_i;
    assign sub.dbg_wr     = cp0_wr_i && hit_dbg;
    assign sub.wdata      = cp0_wdata_i;

    linked_load_tracker u_ll (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .sub       (sub.ll)
    );

    debug_status_capture #(
        .SEG_ABSENT (SEG_ABSENT),
        .DBG_VER    (DBG_VER)
    ) u_dbg (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .sub       (sub.dbg)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_d          = st_q;
        st_d.rvalid   = 1'h0;
        st_d.software_debug_breakpoint_instr_ri = software_debug_breakpoint_instr_exec_i && !kernel_mode_i && st_q.breakpoint_restriction_ctl;
        st_d.sync_ext = sync_instr_i && st_q.es;
        st_d.dm       = sub.dbg_word[cp0_regs_pkg::DBG_DM_BIT];
        st_d.segment_routing_ctl     = sub.dbg_word[cp0_regs_pkg::DBG_ROUTE_BIT];
        st_d.link_bit      = sub.ll_word[0];
        if (cp0_wr_i) begin
            // of the capability words only the two control bits take writes; linked-load and debug writes go to their keepers
            if (hit_cap5) begin
                st_d.breakpoint_restriction_ctl = cp0_wdata_i[cp0_regs_pkg::BRK_RESTRICT_BIT];
            end
            if (hit_impl) begin
                st_d.es = cp0_wdata_i[cp0_regs_pkg::EXT_SYNC_BIT];
            end
        end
        if (cp0_rd_i) begin
            st_d.rvalid = 1'h1;
            if (hit_cap3) begin
                st_d.rdata = cap3_word;
            end else if (hit_cap4) begin
                st_d.rdata = cap4_word;
            end else if (hit_cap5) begin
                st_d.rdata = cap5_word;
            end else if (hit_impl) begin
                st_d.rdata = impl_word;
            end else if (hit_ll) begin
                st_d.rdata = sub.ll_word;
            end else if (hit_dbg) begin
                st_d.rdata = sub.dbg_word;
            end else begin
                st_d.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign cp0_rdata_o   = st_q.rdata;
    assign cp0_rvalid_o  = st_q.rvalid;
    assign software_debug_breakpoint_instr_ri_o    = st_q.software_debug_breakpoint_instr_ri;
    assign sync_ext_o    = st_q.sync_ext;
    assign debug_mode_o  = st_q.dm;
    assign seg_to_main_o = st_q.segment_routing_ctl;
    assign link_bit_o    = st_q.link_bit;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_cap3_low: assert property (ce_i && cp0_rd_i && hit_cap3 |=>
        cp0_rvalid_o && cp0_rdata_o[1:0] == 2'h0)
        else $error("third capability low bits not zero");

    a_cap4_word: assert property (ce_i && cp0_rd_i && hit_cap4 |=>
        cp0_rdata_o == 32'h80FC_0000)
        else $error("fourth capability word wrong");

    a_cap5_word: assert property (ce_i && cp0_rd_i && hit_cap5 |=>
        cp0_rdata_o == (32'h0000_0031 | {25'h0, $past(st_q.breakpoint_restriction_ctl), 6'h00}))
        else $error("fifth capability word wrong");

    a_impl_word: assert property (ce_i && cp0_rd_i && hit_impl |=>
        cp0_rdata_o == {23'h0, $past(st_q.es), 8'h00})
        else $error("implementation control word wrong");

    a_brk_trap: assert property (ce_i && st_q.breakpoint_restriction_ctl && software_debug_breakpoint_instr_exec_i && !kernel_mode_i
        |=> software_debug_breakpoint_instr_ri_o)
        else $error("user breakpoint not trapped");

    a_brk_free: assert property (ce_i && (!st_q.breakpoint_restriction_ctl || kernel_mode_i) |=> !software_debug_breakpoint_instr_ri_o)
        else $error("breakpoint trapped without restriction");

    a_sync_ext: assert property (ce_i && sync_instr_i |=> sync_ext_o == $past(st_q.es))
        else $error("sync externalisation wrong");

    a_ro_write: assert property (ce_i && cp0_wr_i && hit_cap4 ##1 ce_i && cp0_rd_i && hit_cap4
        |=> cp0_rdata_o == 32'h80FC_0000)
        else $error("read-only word changed by write");

    a_dm_follow: assert property (ce_i && debug_exc_i ##1 ce_i |=> debug_mode_o)
        else $error("debug mode flag not raised");

    a_ll_bit: assert property (ce_i && ll_exec_i ##1 ce_i |=> link_bit_o)
        else $error("link bit not raised");

    a_unmapped_rd: assert property (ce_i && cp0_rd_i && !(hit_cap3 || hit_cap4
        || hit_cap5 || hit_impl || hit_ll || hit_dbg) |=> cp0_rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_breakpoint_restriction_ctl_write: assert property (ce_i && cp0_wr_i && hit_cap5 |=>
        st_q.breakpoint_restriction_ctl == $past(cp0_wdata_i[cp0_regs_pkg::BRK_RESTRICT_BIT]))
        else $error("restriction bit write lost");

    a_es_write: assert property (ce_i && cp0_wr_i && hit_impl |=>
        st_q.es == $past(cp0_wdata_i[cp0_regs_pkg::EXT_SYNC_BIT]))
        else $error("externalise-sync write lost");

    a_ll_top: assert property (ce_i && cp0_rd_i && hit_ll |=>
        cp0_rdata_o[31:28] == 4'h0)
        else $error("linked address top bits not zero");

    a_ll_addr_read: assert property (ce_i && ll_exec_i ##1 ce_i && cp0_rd_i && hit_ll |=>
        cp0_rdata_o[27:1] == $past(ll_paddr_i[31:5], 2))
        else $error("linked address read wrong");

    a_seg_absent: assert property (ce_i && cp0_rd_i && hit_dbg |=>
        cp0_rdata_o[cp0_regs_pkg::DBG_NOSEG_BIT] == SEG_ABSENT)
        else $error("segment absence flag wrong");

    a_dbg_ver: assert property (ce_i && cp0_rd_i && hit_dbg |=>
        cp0_rdata_o[cp0_regs_pkg::DBG_VER_LSB +: 3] == DBG_VER)
        else $error("debug version field wrong");

    a_dbg_reserved: assert property (ce_i && cp0_rd_i && hit_dbg |=>
        cp0_rdata_o[25:18] == 8'h00 && cp0_rdata_o[9:0] == 10'h000)
        else $error("debug reserved bits not zero");

    // ************************************************************
    // checks of the debug capture and the event outputs
    // ************************************************************

    a_dbd_read: assert property (ce_i && debug_exc_i ##1 ce_i && cp0_rd_i && hit_dbg |=>
        cp0_rdata_o[cp0_regs_pkg::DBG_DBD_BIT] == $past(delay_slot_i, 2))
        else $error("delay-slot flag not captured");

    a_doze_read: assert property (ce_i && debug_exc_i ##1 ce_i && cp0_rd_i && hit_dbg |=>
        cp0_rdata_o[cp0_regs_pkg::DBG_LOWPWR_BIT] == $past(low_power_i, 2))
        else $error("low-power flag not captured");

    a_halt_read: assert property (ce_i && debug_exc_i ##1 ce_i && cp0_rd_i && hit_dbg |=>
        cp0_rdata_o[cp0_regs_pkg::DBG_HALT_BIT] == $past(bus_clk_run_i, 2))
        else $error("bus-halt flag not captured");

    a_dexc_read: assert property (ce_i && dmode_exc_i && !debug_exc_i
        && sub.dbg_word[cp0_regs_pkg::DBG_DM_BIT] ##1 ce_i && cp0_rd_i && hit_dbg
        |=> cp0_rdata_o[cp0_regs_pkg::DBG_CODE_LSB +: 5] == $past(exc_code_i, 2))
        else $error("cause code not captured");

    a_dm_read: assert property (ce_i && deret_i && !debug_exc_i && !dmode_exc_i ##1
        ce_i && cp0_rd_i && hit_dbg |=> !cp0_rdata_o[cp0_regs_pkg::DBG_DM_BIT])
        else $error("debug-mode flag not cleared");

    a_sync_off: assert property (ce_i && !st_q.es |=> !sync_ext_o)
        else $error("sync externalised while disabled");

    a_llb_sw_clear: assert property (ce_i && cp0_wr_i && hit_ll && !cp0_wdata_i[0]
        && !ll_exec_i ##1 ce_i |=> !link_bit_o)
        else $error("software clear of link bit lost");

    c_user_trap: cover property (ce_i && st_q.breakpoint_restriction_ctl && software_debug_breakpoint_instr_exec_i && !kernel_mode_i);
    c_dbg_entry: cover property (ce_i && debug_exc_i ##1 ce_i && dmode_exc_i);
    c_ll_clear: cover property (ce_i && ll_exec_i ##1 ce_i && llb_clear_i);
    c_sync_out: cover property (sync_ext_o);
    c_dbg_read: cover property (ce_i && cp0_rd_i && hit_dbg && debug_mode_o);
endmodule

// ==== src/debug_status_capture.sv ====
// upper fields of the debug control/status register
`timescale 1ns/1ns
module debug_status_capture #(
    parameter logic       SEG_ABSENT = 1'h0,
    parameter logic [2:0] DBG_VER    = cp0_regs_pkg::DBG_VER_RESET
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    cp0_sub_if.dbg    sub
);
    typedef struct packed {
        logic       dbd;
        logic       dm;
        logic       segment_routing_ctl;
        logic       doze;
        logic       halt;
        logic [4:0] dexc;
    } dbg_state_s;

    dbg_state_s st_q;
    dbg_state_s st_d;

    always_comb begin
        st_d = st_q;
        if (sub.dbg_exc) begin
            st_d.dm   = 1'h1;
            st_d.dbd  = sub.delay_slot;
            st_d.doze = sub.low_power;
            st_d.halt = sub.bus_run;
        end else if (sub.dmode_exc && st_q.dm) begin
            st_d.dbd  = sub.delay_slot;
            st_d.dexc = sub.exc_code;
        end else if (sub.deret) begin
            st_d.dm   = 1'h0;
        end else if (sub.dbg_wr && st_q.dm) begin
            // writes outside debug mode are dropped
            st_d.segment_routing_ctl = sub.wdata[cp0_regs_pkg::DBG_ROUTE_BIT];
            st_d.dexc = sub.wdata[cp0_regs_pkg::DBG_CODE_LSB +: 5];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q      <= '0;
            st_q.doze <= cp0_regs_pkg::LOWPWR_RESET;
            st_q.halt <= cp0_regs_pkg::HALT_RESET;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    assign sub.dbg_word = {st_q.dbd, st_q.dm, SEG_ABSENT, st_q.segment_routing_ctl, st_q.doze, st_q.halt,
                           8'h00, DBG_VER, st_q.dexc, 10'h000};

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_dm_entry: assert property (ce_i && sub.dbg_exc |=> st_q.dm &&
        st_q.doze == $past(sub.low_power) && st_q.halt == $past(sub.bus_run))
        else $error("debug entry not captured");
    a_dexc_hold: assert property (ce_i && !(sub.dmode_exc && st_q.dm) && !(sub.dbg_wr && st_q.dm)
        |=> $stable(st_q.dexc))
        else $error("cause code moved without exception in debug mode");
    a_route_guard: assert property (ce_i && !st_q.dm |=> st_q.segment_routing_ctl == $past(st_q.segment_routing_ctl))
        else $error("segment routing changed outside debug mode");
endmodule

// ==== src/linked_load_tracker.sv ====
// linked-load address register with its link bit
`timescale 1ns/1ns
module linked_load_tracker (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    cp0_sub_if.ll     sub
);
    typedef struct packed {
        logic [26:0] paddr;
        logic        link_bit;
    } ll_state_s;

    ll_state_s st_q;
    ll_state_s st_d;

    always_comb begin
        st_d = st_q;
        if (sub.ll_exec) begin
            st_d.paddr = sub.ll_paddr[31:cp0_regs_pkg::PADDR_LSB];
            st_d.link_bit   = 1'h1;
        end else if (sub.llb_clear || (sub.ll_wr && !sub.wdata[0])) begin
            st_d.link_bit   = 1'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    assign sub.ll_word = {4'h0, st_q.paddr, st_q.link_bit};

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_ll_capture: assert property (ce_i && sub.ll_exec |=>
        sub.ll_word[27:1] == $past(sub.ll_paddr[31:5]) && sub.ll_word[0])
        else $error("linked address not captured");
    a_llb_no_set: assert property (ce_i && !sub.ll_exec && !st_q.link_bit |=> !st_q.link_bit)
        else $error("link bit set without load-linked");
    a_llb_clear: assert property (ce_i && !sub.ll_exec && sub.llb_clear |=> !st_q.link_bit)
        else $error("link bit not cleared");
endmodule
